// >>> hw/sdcr_pkg.sv
package sdcr_pkg;
    // ------------------------------------------------------------
    // Register addresses and widths
    // ------------------------------------------------------------
    localparam int ADDR_W = 4;
    localparam int DATA_W = 9;
    localparam int CODE_W = 8;
    localparam int SAMP_W = 24;
    localparam logic [3:0] ADDR_LEFT_GAIN  = 4'h0;
    localparam logic [3:0] ADDR_RIGHT_GAIN = 4'h1;
    localparam logic [3:0] ADDR_CONV_CTRL  = 4'h2;
    localparam logic [3:0] ADDR_INTF_CTRL  = 4'h3;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_COMMIT      = 8;
    localparam int BIT_SILENCE     = 0;
    localparam int BIT_EMPHASIS    = 1;
    localparam int BIT_POWER_SAVE  = 2;
    localparam int BIT_FMT_LO      = 3;
    localparam int BIT_FMT_HI      = 5;
    localparam int BIT_FMT_MSB     = 0;
    localparam int BIT_FRAME_POL   = 1;
    localparam int BIT_SHARED_GAIN = 2;
    localparam int BIT_PHASE_INV   = 4;
    localparam int BIT_BITCLK_POL  = 5;
    localparam int BIT_ZERO_DETECT = 8;

    // ------------------------------------------------------------
    // Reset values and counts
    // ------------------------------------------------------------
    localparam logic [7:0] GAIN_RESET  = 8'hff;
    localparam logic [7:0] GAIN_MUTE   = 8'h00;
    localparam int         ZERO_RUN    = 1024;
    localparam int         GAIN_STEPS  = 256;

    // ------------------------------------------------------------
    // Decoded audio formats
    // ------------------------------------------------------------
    typedef enum logic [3:0] {
        SDCR_RJ16, SDCR_RJ20, SDCR_RJ24, SDCR_LJ24,
        SDCR_SS16, SDCR_SS24, SDCR_SS20, SDCR_LJ20,
        SDCR_DSP16, SDCR_DSP20, SDCR_DSP24, SDCR_DSP32,
        SDCR_LJ16, SDCR_FMT_BAD
    } sdcr_fmt_t;
endpackage

// >>> hw/sdcr_gain.sv
`timescale 1ns/1ps
`default_nettype none
// Scales one channel's sample; code 0 is full mute, 0xff is unity.
// Linear steps of 1/256 of the sample per code below 0xff, kept small on purpose.
module sdcr_gain
    import sdcr_pkg::*;
#(
    parameter int W = SAMP_W
)(
    input  wire logic             clk_sys,
    input  wire logic             rst,
    input  wire logic [CODE_W-1:0] code,
    input  wire logic             invert,
    input  wire logic [W-1:0]     sample_in,
    output logic      [W-1:0]     sample_out
);
    logic [W-1:0]      next_sample_out;
    logic [W+CODE_W:0] prod;

    always_comb
    begin
        prod = $signed({sample_in[W-1], sample_in}) * $signed({1'b0, code});
        next_sample_out = (code == GAIN_RESET) ? sample_in : prod[W+CODE_W-1:CODE_W];
        if (invert)
        begin
            next_sample_out = W'(-next_sample_out);
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sample_out <= '0;
        end
        else
        begin
            sample_out <= next_sample_out;
        end
    end
endmodule
`default_nettype wire

// >>> hw/sdcr_regs.sv
`timescale 1ns/1ps
`default_nettype none
module sdcr_regs
    import sdcr_pkg::*;
#(
    parameter int ZERO_COUNT = ZERO_RUN
)(
    input  wire logic              clk_sys,
    input  wire logic              rst,
    input  wire logic              wr_en,
    input  wire logic [ADDR_W-1:0] wr_addr,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic              sample_valid,
    input  wire logic [SAMP_W-1:0] left_sample_in,
    input  wire logic [SAMP_W-1:0] right_sample_in,
    output logic      [SAMP_W-1:0] left_channel,
    output logic      [SAMP_W-1:0] right_channel,
    output logic      [CODE_W-1:0] left_gain_code,
    output logic      [CODE_W-1:0] right_gain_code,
    output logic                   soft_silence_sel,
    output logic                   emphasis_filter_on,
    output logic                   power_save_sel,
    output logic      [3:0]        word_format_sel,
    output sdcr_fmt_t              word_format,
    output logic                   frame_clock_polarity,
    output logic                   shared_left_gain,
    output logic                   phase_invert,
    output logic                   bit_clock_polarity,
    output logic                   zero_detect_enable,
    output logic                   zero_flag
);
    localparam int ZC_W = $clog2(ZERO_COUNT + 1);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [CODE_W-1:0] left_pend;
    logic [CODE_W-1:0] right_pend;
    logic [CODE_W-1:0] left_act;
    logic [CODE_W-1:0] right_act;
    logic [DATA_W-1:0] conv_bits;
    logic [DATA_W-1:0] intf_bits;
    logic [ZC_W-1:0]   zero_cnt;
    logic [CODE_W-1:0] next_left_pend;
    logic [CODE_W-1:0] next_right_pend;
    logic [CODE_W-1:0] next_left_act;
    logic [CODE_W-1:0] next_right_act;
    logic [DATA_W-1:0] next_conv_bits;
    logic [DATA_W-1:0] next_intf_bits;
    logic [ZC_W-1:0]   next_zero_cnt;
    logic              next_zero_flag;
    logic              commit;
    logic              both_zero;
    logic [CODE_W-1:0] right_eff;

    // ------------------------------------------------------------
    // Register writes
    // ------------------------------------------------------------
    always_comb
    begin
        next_left_pend  = left_pend;
        next_right_pend = right_pend;
        next_conv_bits  = conv_bits;
        next_intf_bits  = intf_bits;
        commit          = 1'b0;
        if (wr_en)
        begin
            unique case (wr_addr)
                ADDR_LEFT_GAIN:
                begin
                    next_left_pend = wr_data[CODE_W-1:0];
                    commit         = wr_data[BIT_COMMIT];
                end
                ADDR_RIGHT_GAIN:
                begin
                    next_right_pend = wr_data[CODE_W-1:0];
                    commit          = wr_data[BIT_COMMIT];
                end
                ADDR_CONV_CTRL:  next_conv_bits = wr_data;
                ADDR_INTF_CTRL:  next_intf_bits = wr_data;
                default:
                begin
                end
            endcase
        end
        // commit moves both pendings, including this write
        next_left_act  = commit ? next_left_pend : left_act;
        next_right_act = commit ? next_right_pend : right_act;
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            left_pend  <= GAIN_RESET;
            right_pend <= GAIN_RESET;
            left_act   <= GAIN_RESET;
            right_act  <= GAIN_RESET;
            conv_bits  <= '0;
            intf_bits  <= '0;
        end
        else
        begin
            left_pend  <= next_left_pend;
            right_pend <= next_right_pend;
            left_act   <= next_left_act;
            right_act  <= next_right_act;
            conv_bits  <= next_conv_bits;
            intf_bits  <= next_intf_bits;
        end
    end

    // ------------------------------------------------------------
    // Field outputs
    // ------------------------------------------------------------
    assign left_gain_code       = left_act;
    assign right_gain_code      = right_act;
    assign soft_silence_sel     = conv_bits[BIT_SILENCE];
    assign emphasis_filter_on   = conv_bits[BIT_EMPHASIS];
    assign power_save_sel       = conv_bits[BIT_POWER_SAVE];
    assign word_format_sel      = {conv_bits[BIT_FMT_HI], intf_bits[BIT_FMT_MSB],
                                   conv_bits[BIT_FMT_HI-1:BIT_FMT_LO]};
    assign frame_clock_polarity = intf_bits[BIT_FRAME_POL];
    assign shared_left_gain     = intf_bits[BIT_SHARED_GAIN];
    assign phase_invert         = intf_bits[BIT_PHASE_INV];
    assign bit_clock_polarity   = intf_bits[BIT_BITCLK_POL];
    assign zero_detect_enable   = intf_bits[BIT_ZERO_DETECT];

    // format decode, order is wide bit, standard bit, low pair
    always_comb
    begin
        unique case (word_format_sel)
            4'h0:    word_format = SDCR_RJ16;
            4'h1:    word_format = SDCR_RJ20;
            4'h2:    word_format = SDCR_RJ24;
            4'h3:    word_format = SDCR_LJ24;
            4'h4:    word_format = SDCR_SS16;
            4'h5:    word_format = SDCR_SS24;
            4'h6:    word_format = SDCR_SS20;
            4'h7:    word_format = SDCR_LJ20;
            4'h8:    word_format = SDCR_DSP16;
            4'h9:    word_format = SDCR_DSP20;
            4'ha:    word_format = SDCR_DSP24;
            4'hb:    word_format = SDCR_DSP32;
            4'hc:    word_format = SDCR_LJ16;
            default: word_format = SDCR_FMT_BAD;
        endcase
    end

    // ------------------------------------------------------------
    // Sample path
    // ------------------------------------------------------------
    // right follows left gain when shared
    assign right_eff = shared_left_gain ? left_act : right_act;

    // gain ahead of the filter stage
    sdcr_gain #(.W(SAMP_W)) u_left (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .code       (left_act),
        .invert     (phase_invert),
        .sample_in  (left_sample_in),
        .sample_out (left_channel)
    );

    sdcr_gain #(.W(SAMP_W)) u_right (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .code       (right_eff),
        .invert     (phase_invert),
        .sample_in  (right_sample_in),
        .sample_out (right_channel)
    );

    // ------------------------------------------------------------
    // Zero detection
    // ------------------------------------------------------------
    assign both_zero = (left_sample_in == '0) && (right_sample_in == '0);

    // count zero pairs, release on any nonzero
    always_comb
    begin
        next_zero_cnt  = zero_cnt;
        next_zero_flag = zero_flag;
        if (!zero_detect_enable)
        begin
            next_zero_cnt  = '0;
            next_zero_flag = 1'b0;
        end
        else if (sample_valid)
        begin
            if (!both_zero)
            begin
                next_zero_cnt  = '0;
                next_zero_flag = 1'b0;
            end
            else if (zero_cnt < ZC_W'(ZERO_COUNT))
            begin
                next_zero_cnt  = zero_cnt + 1'b1;
                next_zero_flag = (zero_cnt == ZC_W'(ZERO_COUNT - 1));
            end
        end
    end

    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            zero_cnt  <= '0;
            zero_flag <= 1'b0;
        end
        else
        begin
            zero_cnt  <= next_zero_cnt;
            zero_flag <= next_zero_flag;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_left_pend_only: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_LEFT_GAIN && !wr_data[BIT_COMMIT])
        |=> (left_act == $past(left_act) && left_pend == $past(wr_data[CODE_W-1:0])))
        else $error("left pending write changed active gain");
    a_right_pend_only: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_RIGHT_GAIN && !wr_data[BIT_COMMIT])
        |=> (right_act == $past(right_act)))
        else $error("right pending write changed active gain");
    a_commit_both: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_LEFT_GAIN && wr_data[BIT_COMMIT])
        |=> (left_act == $past(wr_data[CODE_W-1:0]) && right_act == $past(right_pend)))
        else $error("commit did not move both channels");
    a_right_commit: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_RIGHT_GAIN && wr_data[BIT_COMMIT])
        |=> (right_act == right_pend && left_act == left_pend))
        else $error("right commit left stages apart");
    a_reset_gain: assert property (@(posedge clk_sys)
        rst |=> (left_act == GAIN_RESET && right_pend == GAIN_RESET
                 && !zero_detect_enable && !zero_flag))
        else $error("reset defaults not loaded");
    a_silence_bit: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_CONV_CTRL)
        |=> (soft_silence_sel == $past(wr_data[BIT_SILENCE])
             && power_save_sel == $past(wr_data[BIT_POWER_SAVE])))
        else $error("control write not reflected");
    a_shared_gain: assert property (@(posedge clk_sys) disable iff (rst)
        (shared_left_gain && left_sample_in == right_sample_in && !phase_invert)
        |=> (left_channel == right_channel))
        else $error("shared gain differs between channels");
    a_zero_release: assert property (@(posedge clk_sys) disable iff (rst)
        (sample_valid && !both_zero) |=> !zero_flag)
        else $error("zero flag held after nonzero sample");
    a_zero_needs_run: assert property (@(posedge clk_sys) disable iff (rst)
        $rose(zero_flag) |-> (zero_cnt == ZC_W'(ZERO_COUNT) && $past(zero_detect_enable)))
        else $error("zero flag raised early");
    a_zero_disabled: assert property (@(posedge clk_sys) disable iff (rst)
        !zero_detect_enable |=> !zero_flag)
        else $error("zero flag set while detection disabled");
    a_intf_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_INTF_CTRL)
        |=> (frame_clock_polarity == $past(wr_data[BIT_FRAME_POL])
             && bit_clock_polarity == $past(wr_data[BIT_BITCLK_POL])
             && zero_detect_enable == $past(wr_data[BIT_ZERO_DETECT])
             && phase_invert == $past(wr_data[BIT_PHASE_INV])))
        else $error("interface control write not reflected");
    a_format_bits: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr == ADDR_CONV_CTRL)
        |=> (word_format_sel[BIT_FMT_HI-BIT_FMT_LO-1:0] == $past(wr_data[BIT_FMT_HI-1:BIT_FMT_LO])
             && emphasis_filter_on == $past(wr_data[BIT_EMPHASIS])))
        else $error("format or emphasis field not reflected");
    a_stray_addr: assert property (@(posedge clk_sys) disable iff (rst)
        (wr_en && wr_addr > ADDR_INTF_CTRL)
        |=> (left_pend == $past(left_pend) && right_pend == $past(right_pend)
             && conv_bits == $past(conv_bits) && intf_bits == $past(intf_bits)))
        else $error("write to unused address changed state");
    a_unity_gain: assert property (@(posedge clk_sys) disable iff (rst)
        (left_act == GAIN_RESET && !phase_invert) |=> (left_channel == $past(left_sample_in)))
        else $error("full scale code did not pass the sample unchanged");
endmodule
`default_nettype wire

// >>> verification/sdcr_host.sv
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Host side of the register write port
// ------------------------------------------------------------
module sdcr_host
    import sdcr_pkg::*;
(
    input  wire logic              clk_sys,
    output logic                   wr_en,
    output logic      [ADDR_W-1:0] wr_addr,
    output logic      [DATA_W-1:0] wr_data
);
    initial
    begin
        wr_en   = 1'b0;
        wr_addr = 4'h0;
        wr_data = 9'h000;
    end

    // Address and data are scrambled once released, so a stale word never passes
    task automatic put_word(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys);
        wr_en   <= 1'b1;
        wr_addr <= a;
        wr_data <= d;
        @(posedge clk_sys);
        wr_en   <= 1'b0;
        wr_addr <= ~a;
        wr_data <= ~d;
    endtask

    task automatic set_stereo(input logic [CODE_W-1:0] l, input logic [CODE_W-1:0] r);
        put_word(ADDR_LEFT_GAIN, {1'b0, l});
        put_word(ADDR_RIGHT_GAIN, {1'b1, r});
    endtask
endmodule
`default_nettype wire

// >>> verification/stereo_dac_control_registers_tb.sv
`timescale 1ns/1ps
`default_nettype none
module stereo_dac_control_registers_tb;
    import sdcr_pkg::*;
    localparam int ZRUN = 8;
    logic clk_sys = 1'b0;
    logic rst = 1'b1;
    logic sample_valid = 1'b0;
    logic [SAMP_W-1:0] l_in = 24'h00_0000;
    logic [SAMP_W-1:0] r_in = 24'h00_0000;
    wire logic wr_en;
    wire logic [ADDR_W-1:0] wr_addr;
    wire logic [DATA_W-1:0] wr_data;
    logic [SAMP_W-1:0] l_out, r_out;
    logic [CODE_W-1:0] lg, rg;
    logic silence, emph, psave, fpol, shared, phase, bpol, zden, zflag;
    logic [3:0] wfs;
    sdcr_fmt_t wfmt;
    logic [8:0] r2 = 9'h000;
    logic [8:0] r3 = 9'h000;
    logic [3:0] fi;
    logic [11:0] ctl_seen;
    int err_total = 0;
    int n_checks = 0;

    assign ctl_seen = {silence, emph, psave, fpol, shared, phase, bpol, zden, wfs};

    always #50 clk_sys = ~clk_sys;

    sdcr_host host (.clk_sys(clk_sys), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));

    sdcr_regs #(.ZERO_COUNT(ZRUN)) uut (
        .clk_sys(clk_sys), .rst(rst), .wr_en(wr_en), .wr_addr(wr_addr),
        .wr_data(wr_data), .sample_valid(sample_valid), .left_sample_in(l_in),
        .right_sample_in(r_in), .left_channel(l_out), .right_channel(r_out),
        .left_gain_code(lg), .right_gain_code(rg), .soft_silence_sel(silence),
        .emphasis_filter_on(emph), .power_save_sel(psave), .word_format_sel(wfs),
        .word_format(wfmt), .frame_clock_polarity(fpol), .shared_left_gain(shared),
        .phase_invert(phase), .bit_clock_polarity(bpol), .zero_detect_enable(zden),
        .zero_flag(zflag)
    );

    // ------------------------------------------------------------
    // Checking and access helpers
    // ------------------------------------------------------------
    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            $display("mismatch %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    function automatic logic [11:0] ctl_exp();
        return {r2[0], r2[1], r2[2], r3[1], r3[2], r3[4], r3[5], r3[8], r2[5], r3[0], r2[4:3]};
    endfunction

    task automatic wr(input logic [3:0] a, input logic [8:0] d);
        host.put_word(a, d);
        if (a == ADDR_CONV_CTRL)
            r2 = d;
        if (a == ADDR_INTF_CTRL)
            r3 = d;
        @(posedge clk_sys);
        #1;
    endtask

    task automatic gains(input logic [7:0] l, input logic [7:0] r);
        chk("left_gain_code", 32'(l), 32'(lg));
        chk("right_gain_code", 32'(r), 32'(rg));
    endtask

    task automatic pair(input logic [23:0] l, input logic [23:0] r);
        @(posedge clk_sys);
        sample_valid <= 1'b1;
        l_in <= l;
        r_in <= r;
        @(posedge clk_sys);
        sample_valid <= 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask

    initial
    begin
        repeat (5000) @(posedge clk_sys);
        err_total++;
        close_out();
    end

    initial
    begin
        repeat (3) @(posedge clk_sys);
        rst <= 1'b0;
        #1;
        chk("control", 32'(ctl_exp()), 32'(ctl_seen));
        gains(8'hff, 8'hff);
        chk("zero_flag", 32'h0, 32'(zflag));
        $display("test reset done");

        wr(ADDR_LEFT_GAIN, 9'h040);
        gains(8'hff, 8'hff);
        wr(ADDR_RIGHT_GAIN, 9'h020);
        gains(8'hff, 8'hff);
        wr(ADDR_LEFT_GAIN, 9'h110);
        gains(8'h10, 8'h20);
        wr(ADDR_RIGHT_GAIN, 9'h1a5);
        gains(8'h10, 8'ha5);
        host.set_stereo(8'h00, 8'hff);
        #1;
        gains(8'h00, 8'hff);
        $display("test gain staging done");

        for (int a = 2; a < 4; a++)
        begin
            for (int b = 0; b < 9; b++)
            begin
                wr(4'(a), 9'h001 << b);
                chk("control", 32'(ctl_exp()), 32'(ctl_seen));
            end
            wr(4'(a), 9'h000);
        end
        wr(ADDR_CONV_CTRL, 9'h03f);
        wr(ADDR_INTF_CTRL, 9'h137);
        wr(4'h6, 9'h000);
        wr(4'hf, 9'h1ff);
        chk("control", 32'(ctl_exp()), 32'(ctl_seen));
        gains(8'h00, 8'hff);
        $display("test control fields done");

        for (int i = 0; i < 16; i++)
        begin
            fi = 4'(i);
            wr(ADDR_CONV_CTRL, {3'b000, fi[3], fi[1:0], 3'b000});
            wr(ADDR_INTF_CTRL, {8'h00, fi[2]});
            chk("word_format_sel", 32'(fi), 32'(wfs));
            chk("word_format", (i < 13) ? 32'(i) : 32'(SDCR_FMT_BAD), 32'(wfmt));
        end
        wr(ADDR_CONV_CTRL, 9'h000);
        wr(ADDR_INTF_CTRL, 9'h000);
        $display("test formats done");

        l_in <= 24'h10_0000;
        r_in <= 24'h10_0000;
        settle();
        chk("left_channel", 32'h0, 32'(l_out));
        chk("right_channel", 32'h0010_0000, 32'(r_out));
        wr(ADDR_INTF_CTRL, 9'h004);
        settle();
        chk("right_channel", 32'h0, 32'(r_out));
        wr(ADDR_LEFT_GAIN, 9'h180);
        settle();
        chk("left_channel", 32'h0008_0000, 32'(l_out));
        chk("right_channel", 32'h0008_0000, 32'(r_out));
        wr(ADDR_INTF_CTRL, 9'h010);
        settle();
        chk("right_channel", 32'h00f0_0000, 32'(r_out));
        $display("test samples done");

        wr(ADDR_INTF_CTRL, 9'h100);
        repeat (ZRUN - 1) pair(24'h00_0000, 24'h00_0000);
        settle();
        chk("zero_flag", 32'h0, 32'(zflag));
        pair(24'h00_0000, 24'h00_0000);
        settle();
        chk("zero_flag", 32'h1, 32'(zflag));
        pair(24'h00_0001, 24'h00_0000);
        settle();
        chk("zero_flag", 32'h0, 32'(zflag));
        $display("test zero detect done");

        @(posedge clk_sys);
        rst <= 1'b1;
        @(posedge clk_sys);
        rst <= 1'b0;
        r3 = 9'h000;
        #1;
        chk("control", 32'(ctl_exp()), 32'(ctl_seen));
        wr(ADDR_LEFT_GAIN, 9'h111);
        gains(8'h11, 8'hff);
        $display("test second reset done");
        close_out();
    end
endmodule
`default_nettype wire
